// file: pkg/ccr_pkg.sv
package ccr_pkg;

    // Special-function byte addresses
    localparam logic [7:0] STACK_PTR_ADDR = 8'h81;
    localparam logic [7:0] EXT_LOW_ADDR   = 8'h82;
    localparam logic [7:0] EXT_HIGH_ADDR  = 8'h83;
    localparam logic [7:0] STATUS_ADDR    = 8'hD0;
    localparam logic [7:0] OPERAND_ADDR   = 8'hE0;
    localparam logic [7:0] AUX_ADDR       = 8'hF0;

    // Reset values
    localparam logic [7:0] STACK_PTR_RST  = 8'h07;
    localparam logic [7:0] EXT_LOW_RST    = 8'h00;
    localparam logic [7:0] EXT_HIGH_RST   = 8'h00;
    localparam logic [7:0] STATUS_RST     = 8'h00;
    localparam logic [7:0] OPERAND_RST    = 8'h00;
    localparam logic [7:0] AUX_RST        = 8'h00;

    // Status word bit positions
    localparam int CARRY_BIT  = 7;
    localparam int NIBBLE_BIT = 6;
    localparam int USER_BIT   = 5;
    localparam int BANK_HI    = 4;
    localparam int BANK_LO    = 3;
    localparam int RANGE_BIT  = 2;
    localparam int SPARE_BIT  = 1;
    localparam int PARITY_BIT = 0;

    // Bit-addressing: bit address base of the status word
    localparam logic [4:0] STATUS_BIT_BASE = 5'h1A;

    // Arithmetic flag update classes from the execute unit
    typedef enum logic [2:0] {
        ARI_NONE,
        ARI_ADD,
        ARI_SUB,
        ARI_MUL,
        ARI_DIV,
        ARI_OTHER
    } ccr_arith_type;

    // Arithmetic result carried from the execute unit
    typedef struct packed {
        ccr_arith_type kind;
        logic          carry;
        logic          nibble;
        logic          signedOvf;
        logic [15:0]   product;
        logic [7:0]    divisor;
    } ccr_alu_type;

    // Register access request from the core
    typedef struct packed {
        logic       wrEn;
        logic       direct;
        logic [7:0] addr;
        logic [7:0] data;
    } ccr_sfr_type;

endpackage : ccr_pkg

// file: hw/ccr_flag_calc.sv
`timescale 1ns/10ps
// Derives next arithmetic flags from one execute result
module ccr_flag_calc
    import ccr_pkg::*;
(
    input  wire ccr_alu_type alu,
    input  wire logic [7:0]  curFlags,
    output logic [7:0]       nxtFlags
);

    // Class decode
    wire isAddSub = (alu.kind == ARI_ADD) || (alu.kind == ARI_SUB);
    wire isMul    = (alu.kind == ARI_MUL);
    wire isDiv    = (alu.kind == ARI_DIV);
    wire isArith  = (alu.kind != ARI_NONE);
    wire ovfUsed  = isAddSub || isMul || isDiv;

    // Overflow causes
    wire mulOvf   = (alu.product > 16'h00FF);
    wire divZero  = (alu.divisor == 8'h00);
    wire rangeErr = (isAddSub & alu.signedOvf) | (isMul & mulOvf)
                  | (isDiv & divZero);

    // Carry flags only on add/sub; other arithmetic clears them
    always_comb begin
        nxtFlags = curFlags;
        if (isArith) begin
            nxtFlags[CARRY_BIT]  = isAddSub & alu.carry;
            nxtFlags[NIBBLE_BIT] = isAddSub & alu.nibble;
        end
        if (ovfUsed) begin
            nxtFlags[RANGE_BIT] = rangeErr;
        end
    end

endmodule : ccr_flag_calc

// file: hw/ccr_core_regs.sv
`timescale 1ns/10ps
// Summary of operation
// - Stack pointer resets to 07H
// - Stack pointer freely loadable, holds last used
// - External pointer 16-bit, or two bytes
// - External pointer drives external-move address
// - Aux register is multiply/divide operand
// - Main operand register at E0H
// - Carry flag on carry or borrow
// - Nibble carry flag on nibble carry
// - User flag changed only by firmware
// - Two bank bits select working bank
// - Range error on overflow, big product, zero divide
// - Range error cleared otherwise by those ops
// - Parity flag tracks accumulator every cycle
// - Status word bits 7..2 individually settable
// - Status word at D0H, reset zero
// - Registers reached by direct address only
module ccr_core_regs
    import ccr_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire ccr_sfr_type sfrReq,
    input  wire logic        bitWr,
    input  wire logic [2:0]  bitSel,
    input  wire logic        bitVal,
    input  wire logic        accWr,
    input  wire logic [7:0]  accData,
    input  wire logic        auxWr,
    input  wire logic [7:0]  auxData,
    input  wire logic        extWr16,
    input  wire logic [15:0] extData16,
    input  wire ccr_alu_type aluRes,
    input  wire logic        pushReq,
    input  wire logic        popReq,
    output logic [7:0]       sfrRdData,
    output logic             sfrHit,
    output logic [7:0]       stackPtr,
    output logic [15:0]      extAddr,
    output logic [7:0]       statusWord,
    output logic [7:0]       operand,
    output logic [7:0]       auxReg,
    output logic [4:0]       bankBase
);

    // Architectural registers
    logic [7:0] stackPtr_ff;
    logic [7:0] extLow_ff;
    logic [7:0] extHigh_ff;
    logic [7:0] status_ff;
    logic [7:0] operand_ff;
    logic [7:0] aux_ff;
    logic [7:0] rdData_ff;
    logic       hit_ff;

    // Next values
    logic [7:0] nxt_stackPtr;
    logic [7:0] nxt_extLow;
    logic [7:0] nxt_extHigh;
    logic [7:0] nxt_status;
    logic [7:0] nxt_operand;
    logic [7:0] nxt_aux;
    logic [7:0] nxt_rdData;

    // Address match helper, shared by write and read decode
    function automatic logic sfrMatch(input ccr_sfr_type r,
                                      input logic [7:0] a);
        sfrMatch = r.direct && (r.addr == a);
    endfunction : sfrMatch

    // Decoded direct-address selects; indirect access never matches
    wire selSp   = sfrMatch(sfrReq, STACK_PTR_ADDR);
    wire selLow  = sfrMatch(sfrReq, EXT_LOW_ADDR);
    wire selHigh = sfrMatch(sfrReq, EXT_HIGH_ADDR);
    wire selStat = sfrMatch(sfrReq, STATUS_ADDR);
    wire selAcc  = sfrMatch(sfrReq, OPERAND_ADDR);
    wire selAux  = sfrMatch(sfrReq, AUX_ADDR);
    wire anySel  = selSp | selLow | selHigh | selStat | selAcc | selAux;
    wire wrReq   = sfrReq.wrEn;

    // Flags from the execute result
    logic [7:0] aluFlags;

    ccr_flag_calc u_flag_calc (
        .alu      (aluRes),
        .curFlags (status_ff),
        .nxtFlags (aluFlags)
    );

    // Accumulator: byte write or implicit-operand write
    assign nxt_operand = (wrReq && selAcc) ? sfrReq.data
                       : accWr ? accData : operand_ff;

    // Aux register: multiply/divide result or plain byte write
    assign nxt_aux = (wrReq && selAux) ? sfrReq.data
                   : auxWr ? auxData : aux_ff;

    // Stack pointer: push pre-increments, pop decrements after read
    assign nxt_stackPtr = (wrReq && selSp) ? sfrReq.data
                        : pushReq ? stackPtr_ff + 8'h01
                        : popReq  ? stackPtr_ff - 8'h01
                        : stackPtr_ff;

    // External pointer: word load or independent byte loads
    assign nxt_extLow  = extWr16 ? extData16[7:0]
                       : (wrReq && selLow) ? sfrReq.data : extLow_ff;
    assign nxt_extHigh = extWr16 ? extData16[15:8]
                       : (wrReq && selHigh) ? sfrReq.data : extHigh_ff;

    // Parity of the accumulator value being loaded this cycle
    wire parityNow = ^nxt_operand;

    // Status word: firmware writes win over flag updates;
    // spare bit reads zero, parity always from accumulator
    logic [7:0] statusMerged;
    always_comb begin
        statusMerged = aluFlags;
        if (wrReq && selStat) begin
            statusMerged = sfrReq.data;
        end else if (bitWr) begin
            statusMerged[bitSel] = bitVal;
        end
        statusMerged[SPARE_BIT]  = 1'b0;
        statusMerged[PARITY_BIT] = parityNow;
    end
    assign nxt_status = statusMerged;

    // Read mux for direct accesses
    assign nxt_rdData = selSp   ? stackPtr_ff
                      : selLow  ? extLow_ff
                      : selHigh ? extHigh_ff
                      : selStat ? status_ff
                      : selAcc  ? operand_ff
                      : selAux  ? aux_ff : 8'h00;

    // Register update
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stackPtr_ff <= STACK_PTR_RST;
            extLow_ff   <= EXT_LOW_RST;
            extHigh_ff  <= EXT_HIGH_RST;
            status_ff   <= STATUS_RST;
            operand_ff  <= OPERAND_RST;
            aux_ff      <= AUX_RST;
            rdData_ff   <= 8'h00;
            hit_ff      <= 1'b0;
        end else begin
            stackPtr_ff <= nxt_stackPtr;
            extLow_ff   <= nxt_extLow;
            extHigh_ff  <= nxt_extHigh;
            status_ff   <= nxt_status;
            operand_ff  <= nxt_operand;
            aux_ff      <= nxt_aux;
            rdData_ff   <= nxt_rdData;
            hit_ff      <= anySel;
        end
    end

    // Outputs straight from flops
    assign stackPtr   = stackPtr_ff;
    assign extAddr    = {extHigh_ff, extLow_ff};
    assign statusWord = status_ff;
    assign operand    = operand_ff;
    assign auxReg     = aux_ff;
    assign sfrRdData  = rdData_ff;
    assign sfrHit     = hit_ff;
    // Bank base is bank bits times eight, 00H..18H
    assign bankBase   = {status_ff[BANK_HI], status_ff[BANK_LO], 3'b000};

    // Checks
    chk_sp_reset: assert property (@(posedge core_clk)
        $fell(sys_rst) |-> stackPtr == 8'h07)
        else $error("stack pointer not 07H after reset");

    chk_push_incr: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        pushReq && !(wrReq && selSp) |=> stackPtr == $past(stackPtr) + 8'h01)
        else $error("push did not increment stack pointer");

    chk_pop_decr: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        popReq && !pushReq && !(wrReq && selSp)
        |=> stackPtr == $past(stackPtr) - 8'h01)
        else $error("pop did not decrement stack pointer");

    chk_sp_load: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        wrReq && selSp |=> stackPtr == $past(sfrReq.data))
        else $error("stack pointer load lost");

    chk_indirect_miss: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        wrReq && !sfrReq.direct && !accWr && !auxWr
        |=> operand == $past(operand) && auxReg == $past(auxReg))
        else $error("indirect access reached a core register");

    chk_read_miss: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        !anySel |=> !sfrHit && sfrRdData == 8'h00)
        else $error("unmapped access returned data or hit");

    chk_ext_word: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        extWr16 |=> extAddr == $past(extData16))
        else $error("external pointer word load lost");

    chk_ext_low: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        wrReq && selLow && !extWr16
        |=> extAddr[7:0] == $past(sfrReq.data))
        else $error("external pointer low byte load lost");

    chk_ext_high: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        wrReq && selHigh && !extWr16
        |=> extAddr[15:8] == $past(sfrReq.data))
        else $error("external pointer high byte load lost");

    chk_acc_load: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        wrReq && selAcc |=> operand == $past(sfrReq.data))
        else $error("main operand byte write lost");

    chk_aux_load: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        auxWr && !(wrReq && selAux) |=> auxReg == $past(auxData))
        else $error("aux register execute write lost");

    chk_parity_track: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        ##1 statusWord[PARITY_BIT] == ^operand)
        else $error("parity flag does not match accumulator");

    chk_mul_range: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        aluRes.kind == ARI_MUL && aluRes.product > 16'h00FF
        && !(wrReq && selStat) && !bitWr |=> statusWord[RANGE_BIT])
        else $error("range error not set on large product");

    chk_ovf_addsub: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (aluRes.kind == ARI_ADD || aluRes.kind == ARI_SUB)
        && aluRes.signedOvf && !(wrReq && selStat) && !bitWr
        |=> statusWord[RANGE_BIT])
        else $error("range error not set on signed overflow");

    chk_div_zero: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        aluRes.kind == ARI_DIV && aluRes.divisor == 8'h00
        && !(wrReq && selStat) && !bitWr |=> statusWord[RANGE_BIT])
        else $error("range error not set on zero divide");

    chk_range_clear: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        aluRes.kind == ARI_DIV && aluRes.divisor != 8'h00
        && !(wrReq && selStat) && !bitWr |=> !statusWord[RANGE_BIT])
        else $error("range error not cleared on good divide");

    chk_carry_add: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        aluRes.kind == ARI_ADD && !(wrReq && selStat) && !bitWr
        |=> statusWord[CARRY_BIT] == $past(aluRes.carry))
        else $error("carry flag wrong after add");

    chk_carry_sub: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        aluRes.kind == ARI_SUB && !(wrReq && selStat) && !bitWr
        |=> statusWord[CARRY_BIT] == $past(aluRes.carry))
        else $error("carry flag wrong after subtract");

    chk_nibble_mul: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        aluRes.kind == ARI_MUL && !(wrReq && selStat) && !bitWr
        |=> !statusWord[NIBBLE_BIT])
        else $error("nibble carry not cleared by multiply");

    chk_nibble_add: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (aluRes.kind == ARI_ADD || aluRes.kind == ARI_SUB)
        && !(wrReq && selStat) && !bitWr
        |=> statusWord[NIBBLE_BIT] == $past(aluRes.nibble))
        else $error("nibble carry wrong after add or subtract");

    chk_user_hold: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        !(wrReq && selStat) && !bitWr
        |=> statusWord[USER_BIT] == $past(statusWord[USER_BIT]))
        else $error("user flag changed without firmware write");

    chk_bit_write: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        bitWr && !(wrReq && selStat) && bitSel == 3'h5
        |=> statusWord[USER_BIT] == $past(bitVal))
        else $error("single-bit write to status word lost");

    chk_bank_base: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        bankBase == 5'(statusWord[4:3] * 8))
        else $error("bank base wrong");

    chk_status_addr: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        wrReq && sfrReq.direct && sfrReq.addr == 8'hD0
        |=> statusWord[7:2] == $past(sfrReq.data[7:2]))
        else $error("status word not at D0H");

    chk_read_status: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        !wrReq && selStat |=> sfrRdData == $past(statusWord))
        else $error("status word read data wrong");

endmodule : ccr_core_regs

// file: dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import ccr_pkg::*;

    logic        core_clk;     // Core clock, 8 ns
    logic        sys_rst;      // Async reset, active high
    ccr_sfr_type sfrReq;       // Direct register access
    logic        bitWr;        // Status bit write strobe
    logic [2:0]  bitSel;       // Status bit position
    logic        bitVal;       // Status bit value
    logic        accWr;        // Implicit operand write
    logic [7:0]  accData;      // Implicit operand data
    logic        auxWr;        // Implicit aux write
    logic [7:0]  auxData;      // Implicit aux data
    logic        extWr16;      // Whole pointer load
    logic [15:0] extData16;    // Whole pointer data
    ccr_alu_type aluRes;       // Execute result
    logic        pushReq;      // Stack push
    logic        popReq;       // Stack pop
    logic [7:0]  sfrRdData;    // Read data
    logic        sfrHit;       // Read matched
    logic [7:0]  stackPtr;     // Stack pointer
    logic [15:0] extAddr;      // External pointer
    logic [7:0]  statusWord;   // Status word
    logic [7:0]  operand;      // Main operand
    logic [7:0]  auxReg;       // Aux register
    logic [4:0]  bankBase;     // Working bank base
    int          nErrors;      // Mismatch count
    int          totalChecks;  // Comparison count

    ccr_core_regs u_ccr_core_regs (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .sfrReq     (sfrReq),
        .bitWr      (bitWr),
        .bitSel     (bitSel),
        .bitVal     (bitVal),
        .accWr      (accWr),
        .accData    (accData),
        .auxWr      (auxWr),
        .auxData    (auxData),
        .extWr16    (extWr16),
        .extData16  (extData16),
        .aluRes     (aluRes),
        .pushReq    (pushReq),
        .popReq     (popReq),
        .sfrRdData  (sfrRdData),
        .sfrHit     (sfrHit),
        .stackPtr   (stackPtr),
        .extAddr    (extAddr),
        .statusWord (statusWord),
        .operand    (operand),
        .auxReg     (auxReg),
        .bankBase   (bankBase)
    );

    // Free running clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Hang guard, well above the real run length
    initial begin
        #80000;
        nErrors++;
        complete_run();
    end

    // Verdict and end of run
    task automatic complete_run;
        if (nErrors == 0 && totalChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    // Four-state compare, so unknowns never match known values
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            nErrors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check

    // Inputs move 1 ns after the edge, away from sampling
    task automatic tick;
        @(posedge core_clk);
        #1;
    endtask : tick

    // Direct byte write, one cycle
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        sfrReq = '{1'b1, 1'b1, a, d};
        tick();
        sfrReq = '0;
        tick();
    endtask : sfr_wr

    // Indirect byte write, must be ignored
    task automatic ind_wr(input logic [7:0] a, input logic [7:0] d);
        sfrReq = '{1'b1, 1'b0, a, d};
        tick();
        sfrReq = '0;
        tick();
    endtask : ind_wr

    // Direct read; data and hit show one cycle later
    task automatic sfr_rd(input logic [7:0] a, input logic [7:0] e,
                          input logic h);
        sfrReq = '{1'b0, 1'b1, a, 8'h00};
        tick();
        sfrReq = '0;
        check(16'(sfrRdData), 16'(e));
        check(16'(sfrHit), 16'(h));
        tick();
    endtask : sfr_rd

    // One execute result, then compare carry, nibble and range bits
    task automatic alu_chk(input ccr_arith_type k, input logic c,
                           input logic n, input logic v,
                           input logic [15:0] p, input logic [7:0] d,
                           input logic [2:0] e);
        aluRes = '{k, c, n, v, p, d};
        tick();
        aluRes.kind = ARI_NONE;
        check(16'({statusWord[7:6], statusWord[2]}), 16'(e));
        tick();
    endtask : alu_chk

    // Main sequence
    initial begin
        {bitWr, bitSel, bitVal, accWr, accData, auxWr, auxData} = '0;
        {extWr16, extData16, pushReq, popReq} = '0;
        sfrReq = '0;
        aluRes = '0;
        nErrors = 0;
        totalChecks = 0;
        sys_rst = 1'b1;
        repeat (5) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        check(16'(stackPtr), 16'h0007);
        check(16'(statusWord), 16'h0000);
        sfr_rd(8'h81, 8'h07, 1'b1);
        sfr_rd(8'h82, 8'h00, 1'b1);
        sfr_rd(8'h83, 8'h00, 1'b1);
        sfr_rd(8'hD0, 8'h00, 1'b1);
        sfr_rd(8'hE0, 8'h00, 1'b1);
        sfr_rd(8'hF0, 8'h00, 1'b1);
        sfr_rd(8'h80, 8'h00, 1'b0);
        // Stack pointer load, indirect refusal, push and pop
        sfr_wr(8'h81, 8'h55);
        check(16'(stackPtr), 16'h0055);
        ind_wr(8'h81, 8'hAA);
        check(16'(stackPtr), 16'h0055);
        pushReq = 1'b1;
        tick();
        pushReq = 1'b0;
        check(16'(stackPtr), 16'h0056);
        popReq = 1'b1;
        tick();
        popReq = 1'b0;
        check(16'(stackPtr), 16'h0055);
        // Push and pop together: push wins
        pushReq = 1'b1;
        popReq = 1'b1;
        tick();
        pushReq = 1'b0;
        popReq = 1'b0;
        check(16'(stackPtr), 16'h0056);
        // External pointer as bytes and as a whole
        sfr_wr(8'h82, 8'h34);
        sfr_wr(8'h83, 8'h12);
        check(extAddr, 16'h1234);
        extWr16 = 1'b1;
        extData16 = 16'hABCD;
        tick();
        extWr16 = 1'b0;
        sfr_rd(8'h82, 8'hCD, 1'b1);
        sfr_rd(8'h83, 8'hAB, 1'b1);
        // Operand and aux, parity follows the operand
        sfr_wr(8'hE0, 8'h07);
        check(16'(operand), 16'h0007);
        check(16'(statusWord[0]), 16'h0001);
        accWr = 1'b1;
        accData = 8'h03;
        tick();
        accWr = 1'b0;
        check(16'(statusWord[0]), 16'h0000);
        sfr_rd(8'hE0, 8'h03, 1'b1);
        ind_wr(8'hE0, 8'hFF);
        check(16'(operand), 16'h0003);
        auxWr = 1'b1;
        auxData = 8'h5A;
        tick();
        auxWr = 1'b0;
        check(16'(auxReg), 16'h005A);
        sfr_wr(8'hF0, 8'hC3);
        sfr_rd(8'hF0, 8'hC3, 1'b1);
        // Whole status byte: bit 1 unused, bit 0 stays parity
        sfr_wr(8'hD0, 8'hFF);
        sfr_rd(8'hD0, 8'hFC, 1'b1);
        check(16'(bankBase), 16'h0018);
        sfr_wr(8'hD0, 8'h00);
        // Every bank through single-bit writes, strobe held up
        bitWr = 1'b1;
        for (int i = 0; i < 4; i++) begin
            bitSel = 3'h4;
            bitVal = i[1];
            tick();
            bitSel = 3'h3;
            bitVal = i[0];
            tick();
            check(16'(bankBase), 16'({i[1:0], 3'b000}));
        end
        bitSel = 3'h5;
        bitVal = 1'b1;
        tick();
        bitWr = 1'b0;
        // Arithmetic flags; the user flag must survive all of it
        alu_chk(ARI_ADD, 1'b1, 1'b1, 1'b1, 16'h0000, 8'h01, 3'b111);
        alu_chk(ARI_ADD, 1'b0, 1'b0, 1'b0, 16'h0000, 8'h01, 3'b000);
        alu_chk(ARI_SUB, 1'b1, 1'b0, 1'b0, 16'h0000, 8'h01, 3'b100);
        alu_chk(ARI_SUB, 1'b0, 1'b1, 1'b0, 16'h0000, 8'h01, 3'b010);
        alu_chk(ARI_OTHER, 1'b1, 1'b1, 1'b0, 16'h0000, 8'h01, 3'b000);
        alu_chk(ARI_MUL, 1'b0, 1'b0, 1'b0, 16'h0100, 8'h01, 3'b001);
        alu_chk(ARI_MUL, 1'b0, 1'b0, 1'b0, 16'h00FF, 8'h01, 3'b000);
        alu_chk(ARI_DIV, 1'b0, 1'b0, 1'b0, 16'h0000, 8'h00, 3'b001);
        alu_chk(ARI_OTHER, 1'b0, 1'b0, 1'b0, 16'h0000, 8'h00, 3'b001);
        alu_chk(ARI_DIV, 1'b0, 1'b0, 1'b0, 16'h0000, 8'h03, 3'b000);
        check(16'(statusWord[5]), 16'h0001);
        // Second reset in mid-run
        sys_rst = 1'b1;
        tick();
        sys_rst = 1'b0;
        check(16'(stackPtr), 16'h0007);
        check(16'(statusWord), 16'h0000);
        complete_run();
    end

endmodule : tb_top
